// file: bench/ctps_line_model.sv
// Line driver model: reports the converter code as each mark phase begins.
`timescale 1ns/1ps

module ctps_line_model (
   // Clock.
   input wire logic core_clk,
   // Converter side of the line driver outputs.
   input wire logic [6:0] magnitude_code,
   input wire logic line_drive_active,
   input wire logic [2:0] line_phase,
   // One sample per phase, phase number above the code.
   output logic smp_valid,
   output logic [9:0] smp_word
);
   logic [2:0] last_q = 3'h0;

   // Only phase entry is sampled, so a code that drifts within a quarter
   // goes unseen; the trade keeps the bench's expectation list short.
   always @(posedge core_clk) begin
      last_q <= line_drive_active ? line_phase : 3'h0;
      smp_valid <= line_drive_active && (line_phase != last_q);
      smp_word <= {line_phase, magnitude_code};
   end
endmodule : ctps_line_model

// file: bench/ctps_top_test.sv
// Self-checking testbench of the custom transmit pulse shaper.
`timescale 1ns/1ps
`include "ctps_consts.svh"

module ctps_top_test;
   import ctps_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic tx_mark = 1'b0, line_drive_active, smp_valid, rd_pend_q = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic [6:0] magnitude_code;
   logic [6:0] w[4];
   logic [6:0] defc[4];
   logic [2:0] line_phase;
   logic [9:0] smp_word;
   logic [9:0] exp_q[$];
   int bad_count = 0, cmp_count = 0;
   logic clk_en = 1'b1;
   // A short quarter mark keeps the run brief; cycles per quarter follow.
   localparam int PH_NS = 12;
   localparam int PH_CYC = PH_NS / `CTPS_CLK_PERIOD_NS;

   initial forever #2 core_clk = ~core_clk;

   ctps_top #(.PHASE_NS(PH_NS)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_mark(tx_mark), .magnitude_code(magnitude_code),
      .line_drive_active(line_drive_active), .line_phase(line_phase));

   ctps_line_model line (.core_clk(core_clk),
      .magnitude_code(magnitude_code),
      .line_drive_active(line_drive_active), .line_phase(line_phase),
      .smp_valid(smp_valid), .smp_word(smp_word));

   task results;
      if (exp_q.size() != 0) bad_count++;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results

   task cmp(input string nm, input logic [9:0] got);
      logic [9:0] e;
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3ff;
      cmp_count++;
      if (e !== got) begin
         $display("[ERR] %s expected %h seen %h", nm, e, got);
         bad_count++;
      end
   endtask : cmp

   // Read data stands only in the cycle after the strobe, so look there.
   always @(posedge core_clk) begin
      rd_pend_q <= reg_rd;
      if (rd_pend_q) cmp("reg_rdata", {2'h0, reg_rdata});
      if (smp_valid) cmp("magnitude_code", smp_word);
   end

   task wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back({2'h0, e});
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd

   // One mark, or two back to back; the wait for the end is bounded.
   task mark(input logic [6:0] c[4], input bit twice);
      int n;
      for (int i = 0; i < (twice ? 8 : 4); i++)
         exp_q.push_back({3'(i % 4 + 1), c[i % 4]});
      @(posedge core_clk);
      tx_mark <= 1'b1;
      @(posedge core_clk);
      tx_mark <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         // The second request lands on the last cycle of phase four.
         tx_mark <= twice && (n == 4 * PH_CYC - 2);
         #1;
         n++;
      end while (line_drive_active !== 1'b0 && n < 64);
      if (line_drive_active !== 1'b0) begin
         bad_count++;
         results();
      end
      cmp_count++;
      if (n != (twice ? 8 : 4) * PH_CYC) begin
         $display("[ERR] mark length expected %0d seen %0d",
            (twice ? 8 : 4) * PH_CYC, n);
         bad_count++;
      end
      repeat (2) @(posedge core_clk);
   endtask : mark

   initial begin
      defc = '{`CTPS_DEF_CODE1, `CTPS_DEF_CODE2, `CTPS_DEF_CODE3,
         `CTPS_DEF_CODE4};
      void'($urandom(32'h8bdb));
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      // Reset values, and an unmapped offset that reads as zero.
      rd(`CTPS_ADDR_CTRL, `CTPS_CTRL_RST);
      for (int i = 0; i < 4; i++) rd(5'h1c + 5'(i), `CTPS_WORD_RST);
      rd(5'h05, 8'h00);
      $display("test reset values done");
      mark(defc, 1'b0);
      $display("test default template done");
      // Boundary codes first, then random ones; bit 7 kept at zero.
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 4; i++) begin
            w[i] = (k == 0) ? ((i % 2) ? 7'h00 : 7'h7f) : 7'($urandom);
            wr(5'h1c + 5'(i), {1'b0, w[i]});
            rd(5'h1c + 5'(i), {1'b0, w[i]});
         end
         wr(`CTPS_ADDR_CTRL, 8'h08);
         mark(w, k == 2);
      end
      $display("test custom codes done");
      // Writes are ignored while the clock enable is low.
      clk_en <= 1'b0;
      wr(`CTPS_ADDR_WORD1, {1'b0, ~w[0]});
      clk_en <= 1'b1;
      rd(`CTPS_ADDR_WORD1, {1'b0, w[0]});
      $display("test clock enable done");
      // Every control bit but the enable set: defaults come back.
      wr(`CTPS_ADDR_CTRL, 8'hf7);
      rd(`CTPS_ADDR_CTRL, 8'hf7);
      mark(defc, 1'b0);
      $display("test enable cleared done");
      results();
   end
endmodule : ctps_top_test

// file: hw/ctps_consts.svh
// Constants of the custom transmit pulse shaper: offsets, fields, timing.
`ifndef CTPS_CONSTS_SVH
`define CTPS_CONSTS_SVH

// Register offsets on the 5-bit register port.
`define CTPS_ADDR_CTRL 5'h11
`define CTPS_ADDR_WORD1 5'h1c
`define CTPS_ADDR_WORD2 5'h1d
`define CTPS_ADDR_WORD3 5'h1e
`define CTPS_ADDR_WORD4 5'h1f

// Field positions.
`define CTPS_CTRL_EN_BIT 3
`define CTPS_CODE_MSB 6
`define CTPS_RSVD_BIT 7

// Reset values.
`define CTPS_WORD_RST 8'h00
`define CTPS_CTRL_RST 8'h00

// Built-in default template, one code per quarter of a mark.
`define CTPS_DEF_CODE1 7'h50
`define CTPS_DEF_CODE2 7'h60
`define CTPS_DEF_CODE3 7'h58
`define CTPS_DEF_CODE4 7'h10

// Timing: one quarter of a mark, in ns, and the core clock period in ns.
`define CTPS_PHASE_NS 81
`define CTPS_CLK_PERIOD_NS 4

`endif

// file: hw/ctps_pkg.sv
// Types of the custom transmit pulse shaper.
package ctps_pkg;

   // Mark sequencer states, Gray coded along idle, 1, 2, 3, 4.
   typedef enum logic [2:0] {
      CTPS_IDLE = 3'h0,
      CTPS_PH1 = 3'h1,
      CTPS_PH2 = 3'h3,
      CTPS_PH3 = 3'h2,
      CTPS_PH4 = 3'h6
   } ctps_state_t;

endpackage : ctps_pkg

// file: hw/ctps_top.sv
// Custom transmit pulse shaper: registers, mark sequencer and converter code.
//
// How it works
// - Phase one of every mark drives the converter with word one's code.
// - Phase two of every mark drives the converter with word two's code.
// - Phase three of every mark drives the converter with word three's code.
// - Phase four of every mark drives the converter with word four's code.
// - Programmed codes are used only while control bit 3 at 11h is one.
// - Codes reach the converter as is, unsigned; bigger code, bigger swing.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "ctps_consts.svh"

module ctps_top
   import ctps_pkg::*;
#(
   parameter int PHASE_NS = `CTPS_PHASE_NS,
   parameter int CLK_PERIOD_NS = `CTPS_CLK_PERIOD_NS,
   parameter int CODE_W = `CTPS_CODE_MSB + 1
) (
   // Clock, reset and clock enable.
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register port.
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Mark request from the transmit encoder.
   input wire logic tx_mark,
   // Converter side of the line driver outputs.
   output logic [CODE_W-1:0] magnitude_code,
   output logic line_drive_active,
   output logic [2:0] line_phase
);

   // Cycles per quarter mark; a longest time rounds down, never below one.
   localparam int PHASE_RAW = PHASE_NS / CLK_PERIOD_NS;
   localparam int PHASE_CYC = (PHASE_RAW < 1) ? 1 : PHASE_RAW;
   localparam int CNT_W = $clog2(PHASE_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PHASE_CYC - 1);

   // Pulse words and control register.
   logic [7:0] word1_q;
   logic [7:0] word2_q;
   logic [7:0] word3_q;
   logic [7:0] word4_q;
   logic [7:0] ctrl_q;
   logic [7:0] rdata_q;

   // Sequencer state.
   ctps_state_t state_q;
   ctps_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CODE_W-1:0] code_q;
   logic [CODE_W-1:0] code_d;
   logic active_q;
   logic [2:0] phase_q;
   logic [2:0] phase_d;

   // Address decode of the register port.
   wire sel_ctrl = reg_addr == `CTPS_ADDR_CTRL;
   wire sel_w1 = reg_addr == `CTPS_ADDR_WORD1;
   wire sel_w2 = reg_addr == `CTPS_ADDR_WORD2;
   wire sel_w3 = reg_addr == `CTPS_ADDR_WORD3;
   wire sel_w4 = reg_addr == `CTPS_ADDR_WORD4;
   wire custom_shape_enable = ctrl_q[`CTPS_CTRL_EN_BIT];

   // Read mux; unmapped offsets read as zero rather than stale data.
   wire [7:0] rd_mux = sel_ctrl ? ctrl_q :
                       sel_w1 ? word1_q :
                       sel_w2 ? word2_q :
                       sel_w3 ? word3_q :
                       sel_w4 ? word4_q : 8'h00;

   // Register writes. Bit 7 is stored as written so software sees it back.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= `CTPS_CTRL_RST;
         word1_q <= `CTPS_WORD_RST;
         word2_q <= `CTPS_WORD_RST;
         word3_q <= `CTPS_WORD_RST;
         word4_q <= `CTPS_WORD_RST;
      end else if (clk_en && reg_wr) begin
         if (sel_ctrl) ctrl_q <= reg_wdata;
         if (sel_w1) word1_q <= reg_wdata;
         if (sel_w2) word2_q <= reg_wdata;
         if (sel_w3) word3_q <= reg_wdata;
         if (sel_w4) word4_q <= reg_wdata;
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
      end else if (clk_en) begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // Phase timing: a mark request is taken in idle or in the last cycle of
   // phase four, so back-to-back marks leave no gap on the line.
   wire phase_done = cnt_q == CNT_LAST;
   wire take_mark = tx_mark &&
                    (state_q == CTPS_IDLE ||
                     (state_q == CTPS_PH4 && phase_done));

   // Next state of the mark sequencer.
   always_comb begin
      state_d = state_q;
      cnt_d = phase_done ? '0 : cnt_q + CNT_W'(1);
      unique case (state_q)
         CTPS_IDLE: begin
            cnt_d = '0;
            if (take_mark) state_d = CTPS_PH1;
         end
         CTPS_PH1: begin
            if (phase_done) state_d = CTPS_PH2;
         end
         CTPS_PH2: begin
            if (phase_done) state_d = CTPS_PH3;
         end
         CTPS_PH3: begin
            if (phase_done) state_d = CTPS_PH4;
         end
         CTPS_PH4: begin
            if (phase_done) state_d = take_mark ? CTPS_PH1 : CTPS_IDLE;
         end
         default: begin
            state_d = CTPS_IDLE;
            cnt_d = '0;
         end
      endcase
   end

   // Code per phase; the custom words win only while the enable is set.
   wire [CODE_W-1:0] c1 = custom_shape_enable ?
                          word1_q[CODE_W-1:0] : `CTPS_DEF_CODE1;
   wire [CODE_W-1:0] c2 = custom_shape_enable ?
                          word2_q[CODE_W-1:0] : `CTPS_DEF_CODE2;
   wire [CODE_W-1:0] c3 = custom_shape_enable ?
                          word3_q[CODE_W-1:0] : `CTPS_DEF_CODE3;
   wire [CODE_W-1:0] c4 = custom_shape_enable ?
                          word4_q[CODE_W-1:0] : `CTPS_DEF_CODE4;

   // The code is picked from the next state so the output flop and the
   // phase stay aligned; the reserved bit 7 never reaches the converter.
   always_comb begin
      unique case (state_d)
         CTPS_PH1: begin
            code_d = c1;
            phase_d = 3'h1;
         end
         CTPS_PH2: begin
            code_d = c2;
            phase_d = 3'h2;
         end
         CTPS_PH3: begin
            code_d = c3;
            phase_d = 3'h3;
         end
         CTPS_PH4: begin
            code_d = c4;
            phase_d = 3'h4;
         end
         default: begin
            code_d = '0;
            phase_d = 3'h0;
         end
      endcase
   end

   // Sequencer and converter output flops; plain binary, no scaling.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= CTPS_IDLE;
         cnt_q <= '0;
         code_q <= '0;
         active_q <= 1'b0;
         phase_q <= 3'h0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         code_q <= code_d;
         active_q <= state_d != CTPS_IDLE;
         phase_q <= phase_d;
      end
   end

   // Outputs straight from flops.
   assign reg_rdata = rdata_q;
   assign magnitude_code = code_q;
   assign line_drive_active = active_q;
   assign line_phase = phase_q;

   // Checks on the converter code, the custom enable, the mark start and the idle outputs against their cause.
   a_phase1_code: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && state_d == CTPS_PH1 && custom_shape_enable
      |=> magnitude_code == $past(word1_q[CODE_W-1:0]))
      else $error("phase one code differs from word one");

   a_phase2_code: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && state_d == CTPS_PH2 && custom_shape_enable
      |=> magnitude_code == $past(word2_q[CODE_W-1:0]))
      else $error("phase two code differs from word two");

   a_phase3_code: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && state_d == CTPS_PH3 && custom_shape_enable
      |=> magnitude_code == $past(word3_q[CODE_W-1:0]))
      else $error("phase three code differs from word three");

   a_phase4_code: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && state_d == CTPS_PH4 && custom_shape_enable
      |=> magnitude_code == $past(word4_q[CODE_W-1:0]))
      else $error("phase four code differs from word four");

   a_enable_write: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && sel_ctrl
      |=> custom_shape_enable == $past(reg_wdata[`CTPS_CTRL_EN_BIT]))
      else $error("custom enable did not follow the control write");

   a_mark_sequence: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && state_q == CTPS_IDLE && tx_mark
      |=> line_drive_active && line_phase == 3'h1)
      else $error("mark request did not start phase one");

   a_default_code: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && state_d == CTPS_PH1 && !custom_shape_enable
      |=> magnitude_code == `CTPS_DEF_CODE1)
      else $error("default template not used while disabled");

   a_idle_quiet: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      !line_drive_active |-> magnitude_code == '0 && line_phase == 3'h0)
      else $error("converter driven outside a mark");

endmodule : ctps_top
